// >>> rtl/mirror_pkg.sv
/*
 Constants for the traffic mirroring block: port count, field widths,
 register offsets and bit positions, reset values.
 Assumes one switch core clock and a 32-bit APB register bus.
*/
package mirror_pkg;
   // ==========================================================
   // Switch geometry
   localparam int NUM_PORTS = 11;         // Ten front ports plus the CPU port
   localparam int CPU_PORT = 10;          // Index of the CPU port in every port mask
   localparam int PORT_W = 4;             // Width of a port number
   localparam int VID_W = 12;             // Width of a VLAN identifier
   localparam int NUM_VIDS = 4096;
   localparam int CPUQ_NUM = 8;           // CPU extraction queues, one bit each
   localparam int CPUQ_W = 3;             // Width of a queue number

   // ==========================================================
   // Register byte offsets
   localparam logic [7:0] OFS_INGRESS_EN = 8'h00;
   localparam logic [7:0] OFS_EGRESS_MASK = 8'h04;
   localparam logic [7:0] OFS_DEST_MASK = 8'h08;
   localparam logic [7:0] OFS_CONTROL = 8'h0C;
   localparam logic [7:0] OFS_VLAN_INDEX = 8'h10;
   localparam logic [7:0] OFS_VLAN_FLAG = 8'h14;
   localparam logic [7:0] OFS_COPY_COUNT = 8'h18;
   localparam logic [7:0] OFS_STATUS = 8'h1C;

   // ==========================================================
   // Control register fields
   localparam int CTL_CPU_COPY_BIT = 0;
   localparam int CTL_LEARN_COPY_BIT = 1;
   localparam int CTL_QSEL_LSB = 4;
   // Status register fields
   localparam int STS_OUT_VALID_BIT = 0;
   localparam int STS_IN_READY_BIT = 1;

   // ==========================================================
   // Reset values
   localparam logic [NUM_PORTS-1:0] MASK_RESET = 11'h000;
   localparam logic [CPUQ_W-1:0] QSEL_RESET = 3'h0;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
   localparam logic [31:0] COUNT_ONE = 32'h0000_0001;

   // ==========================================================
   // Buffered descriptor layout, from the low end upward
   localparam int DESC_W = PORT_W + VID_W + 2 * NUM_PORTS + CPUQ_NUM + 1 + CPUQ_W + 1;
endpackage

// >>> rtl/mirror_skid_buffer.sv
/*
 Two-entry buffer with valid and ready on both sides.
 Assumes both sides run on the same clock; outputs come from flip-flops.
*/
`timescale 1ns/1ps
`default_nettype none
module mirror_skid_buffer #(
   parameter int WIDTH = 8
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   // ==========================================================
   // Storage
   logic [WIDTH-1:0] main_ff, nxt_main, skid_ff, nxt_skid;
   logic mainValid_ff, nxt_mainValid, skidValid_ff, nxt_skidValid;
   logic inReady_ff;

   // Ready is its own flip-flop, the inverse of the spare slot's valid,
   // so there is no path from outReady to inReady
   assign inReady = inReady_ff;
   assign outValid = mainValid_ff;
   assign outData = main_ff;

   // Next state: drain main, refill from skid first to keep order
   always_comb begin
      logic take;
      logic drain;
      take = inValid & ~skidValid_ff;
      drain = mainValid_ff & outReady;
      nxt_main = main_ff;
      nxt_skid = skid_ff;
      nxt_mainValid = mainValid_ff;
      nxt_skidValid = skidValid_ff;
      if (!mainValid_ff || drain) begin
         if (skidValid_ff) begin
            nxt_main = skid_ff;
            nxt_mainValid = 1'b1;
            nxt_skidValid = 1'b0;
         end else begin
            nxt_main = inData;
            nxt_mainValid = take;
         end
      end else if (take) begin
         nxt_skid = inData;          // Receiver stalled: park the word
         nxt_skidValid = 1'b1;
      end
   end

   // Registers
   always_ff @(posedge clk) begin
      if (!nrst) begin
         main_ff <= '0;
         skid_ff <= '0;
         mainValid_ff <= 1'b0;
         skidValid_ff <= 1'b0;
         inReady_ff <= 1'b1;
      end else begin
         main_ff <= nxt_main;
         skid_ff <= nxt_skid;
         mainValid_ff <= nxt_mainValid;
         skidValid_ff <= nxt_skidValid;
         inReady_ff <= ~nxt_skidValid;
      end
   end
endmodule
`default_nettype wire

// >>> rtl/switch_traffic_mirroring.sv
/*
 Mirror selection stage of the switch analyzer, with its APB registers.
 Each forwarding descriptor gets a copy mask and a CPU copy queue beside
 its untouched original fields, then passes a two-entry buffer.
 Assumes descriptors and APB run on the core clock clk, reset nrst low.
*/
// Implementation choices: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module switch_traffic_mirroring
   import mirror_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Descriptor from the forwarding lookup
   input wire logic frameValid,
   output logic frameReady,
   input wire logic [PORT_W-1:0] srcPort,
   input wire logic [VID_W-1:0] classVid,
   input wire logic [NUM_PORTS-1:0] fwdMask,
   input wire logic [CPUQ_NUM-1:0] cpuQueues,
   input wire logic learnFrame,
   input wire logic ruleCopy,
   // Descriptor toward the queue system
   output logic outValid,
   input wire logic outReady,
   output logic [PORT_W-1:0] outSrcPort,
   output logic [VID_W-1:0] outVid,
   output logic [NUM_PORTS-1:0] outFwdMask,
   output logic [CPUQ_NUM-1:0] outCpuQueues,
   output logic [NUM_PORTS-1:0] outCopyMask,
   output logic outCopyToCpu,
   output logic [CPUQ_W-1:0] outCopyQueue,
   output logic outCopyHit
);
   // ==========================================================
   // Configuration and status state. Plain flip-flops, so a read shows
   // what the selection logic uses in that cycle and a write takes
   // effect on the next descriptor taken.
   logic [NUM_PORTS-1:0] ingressCopyEnable_ff, nxt_ingressCopyEnable;
   logic [NUM_PORTS-1:0] egressCopyPortMask_ff, nxt_egressCopyPortMask;
   logic [NUM_PORTS-1:0] copyDestinationMask_ff, nxt_copyDestinationMask;
   logic cpuCopy_ff, nxt_cpuCopy;
   logic learnCopy_ff, nxt_learnCopy;
   logic [CPUQ_W-1:0] cpuCopyQueueSelect_ff, nxt_cpuCopyQueueSelect;
   logic [VID_W-1:0] vlanTableIndex_ff, nxt_vlanTableIndex;
   logic [31:0] copyCount_ff, nxt_copyCount;
   logic [31:0] prdata_ff, nxt_prdata;
   logic pready_ff, nxt_pready;
   logic pslverr_ff, nxt_pslverr;

   // Per-VID copy flags, one bit per VLAN. Reached through the index and
   // flag registers, so 4096 flags cost two words of address space;
   // a read returns the flag at the index as it stands.
   logic perVidCopyFlag [NUM_VIDS];

   // ==========================================================
   // Bus decode
   logic access;
   logic wrStrobe;
   logic vlanFlagWrite;
   logic addrHit;
   logic addrWritable;

   // Register map, one aligned 32-bit word each; narrow fields sit
   // in the low bits and unused upper bits read as zero:
   //   ingress copy enable  one bit per receiving port
   //   egress copy mask     one bit per transmitting port
   //   destination mask     one bit per port, CPU port included
   //   control              CPU copy, learn copy, CPU copy queue
   //   VLAN table index     picks the flag seen at the flag word
   //   VLAN copy flag       bit 0, flag of the indexed VLAN
   //   copy count           descriptors taken with a copy
   //   status               buffer state, read-only

   // Read data and error are latched at the edge ending the first access
   // cycle and stand one cycle with pready. A write commits at the edge
   // where the master sees pready high, so it lands exactly once;
   // masking with pready_ff keeps a held request from answering twice.
   assign access = psel & penable & ~pready_ff;
   assign wrStrobe = psel & penable & pready_ff & pwrite & addrWritable;
   assign vlanFlagWrite = wrStrobe & (paddr == OFS_VLAN_FLAG);

   // Address map check: an address outside the map answers with an
   // error and has no effect; the two read-only words refuse writes
   // the same way, so software sees a bad write at once
   always_comb begin
      addrHit = 1'b1;
      addrWritable = 1'b1;
      unique case (paddr)
         OFS_INGRESS_EN, OFS_EGRESS_MASK, OFS_DEST_MASK, OFS_CONTROL,
         OFS_VLAN_INDEX, OFS_VLAN_FLAG: begin
            addrWritable = 1'b1;
         end
         OFS_COPY_COUNT, OFS_STATUS: begin
            addrWritable = 1'b0;          // Read-only state
         end
         default: begin
            addrHit = 1'b0;
            addrWritable = 1'b0;
         end
      endcase
   end

   // ==========================================================
   // Copy selection
   logic [DESC_W-1:0] descIn, descOut;
   logic bufInReady;
   logic accept;
   logic ingressHit, egressHit, vlanHit, cpuHit, learnHit, copyHit;
   logic [NUM_PORTS-1:0] copyMask;
   logic copyToCpu;

   // Each condition is evaluated independently and OR-ed together.
   // Several hits on one frame still give one copy per destination, so
   // a probe port with ingress and egress copying sends each received
   // and each sent frame once; the copy port may then congest.
   always_comb begin
      ingressHit = 1'b0;
      if (srcPort < PORT_W'(NUM_PORTS)) begin
         ingressHit = ingressCopyEnable_ff[srcPort];
      end
      egressHit = |(fwdMask & egressCopyPortMask_ff);
      vlanHit = perVidCopyFlag[classVid];
      cpuHit = cpuCopy_ff & (|cpuQueues);
      learnHit = learnCopy_ff & learnFrame;
      // Rule match needs no port or VLAN flag
      copyHit = ingressHit | egressHit | vlanHit | cpuHit | learnHit | ruleCopy;
      // One descriptor carries one copy mask even if several conditions hit
      copyMask = copyHit ? copyDestinationMask_ff : MASK_RESET;
      copyToCpu = copyMask[CPU_PORT];
   end

   // Original fields pass unchanged; the copy travels beside them, so
   // the normal forwarding decision never sees it. Low end first:
   // source port, VID, forwarding mask, CPU queues, copy mask,
   // CPU copy flag, CPU copy queue, copy hit; the unpack matches.
   assign descIn = {copyHit, cpuCopyQueueSelect_ff, copyToCpu, copyMask,
                    cpuQueues, fwdMask, classVid, srcPort};
   assign accept = frameValid & bufInReady;

   // ==========================================================
   // Output buffer: a stalled receiver holds words instead of losing them.
   // Two entries let the upstream side run back to back while the far
   // side keeps ready high, at the cost of one cycle of latency.
   mirror_skid_buffer #(
      .WIDTH(DESC_W)
   ) u_buffer (
      .clk(clk),
      .nrst(nrst),
      .inValid(frameValid),
      .inReady(bufInReady),
      .inData(descIn),
      .outValid(outValid),
      .outReady(outReady),
      .outData(descOut)
   );

   assign frameReady = bufInReady;
   assign {outCopyHit, outCopyQueue, outCopyToCpu, outCopyMask,
           outCpuQueues, outFwdMask, outVid, outSrcPort} = descOut;

   // ==========================================================
   // Register writes; a field takes only its own low bits of the word,
   // nothing is refused by content, so software must not rely on upper
   // bits being kept
   always_comb begin
      nxt_ingressCopyEnable = ingressCopyEnable_ff;
      nxt_egressCopyPortMask = egressCopyPortMask_ff;
      nxt_copyDestinationMask = copyDestinationMask_ff;
      nxt_cpuCopy = cpuCopy_ff;
      nxt_learnCopy = learnCopy_ff;
      nxt_cpuCopyQueueSelect = cpuCopyQueueSelect_ff;
      nxt_vlanTableIndex = vlanTableIndex_ff;
      if (wrStrobe) begin
         unique case (paddr)
            OFS_INGRESS_EN: begin
               nxt_ingressCopyEnable = pwdata[NUM_PORTS-1:0];
            end
            OFS_EGRESS_MASK: begin
               nxt_egressCopyPortMask = pwdata[NUM_PORTS-1:0];
            end
            OFS_DEST_MASK: begin
               nxt_copyDestinationMask = pwdata[NUM_PORTS-1:0];
            end
            OFS_CONTROL: begin
               nxt_cpuCopy = pwdata[CTL_CPU_COPY_BIT];
               nxt_learnCopy = pwdata[CTL_LEARN_COPY_BIT];
               nxt_cpuCopyQueueSelect = pwdata[CTL_QSEL_LSB +: CPUQ_W];
            end
            OFS_VLAN_INDEX: begin
               nxt_vlanTableIndex = pwdata[VID_W-1:0];
            end
            default: begin
               nxt_vlanTableIndex = vlanTableIndex_ff;   // Flag write handled by the table
            end
         endcase
      end
   end

   // Register read data and answer
   always_comb begin
      nxt_pready = access;
      nxt_pslverr = access & (~addrHit | (pwrite & ~addrWritable));
      nxt_prdata = WORD_ZERO;
      if (access && !pwrite) begin
         unique case (paddr)
            OFS_INGRESS_EN: begin
               nxt_prdata[NUM_PORTS-1:0] = ingressCopyEnable_ff;
            end
            OFS_EGRESS_MASK: begin
               nxt_prdata[NUM_PORTS-1:0] = egressCopyPortMask_ff;
            end
            OFS_DEST_MASK: begin
               nxt_prdata[NUM_PORTS-1:0] = copyDestinationMask_ff;
            end
            OFS_CONTROL: begin
               nxt_prdata[CTL_CPU_COPY_BIT] = cpuCopy_ff;
               nxt_prdata[CTL_LEARN_COPY_BIT] = learnCopy_ff;
               nxt_prdata[CTL_QSEL_LSB +: CPUQ_W] = cpuCopyQueueSelect_ff;
            end
            OFS_VLAN_INDEX: begin
               nxt_prdata[VID_W-1:0] = vlanTableIndex_ff;
            end
            OFS_VLAN_FLAG: begin
               nxt_prdata[0] = perVidCopyFlag[vlanTableIndex_ff];
            end
            OFS_COPY_COUNT: begin
               nxt_prdata = copyCount_ff;
            end
            OFS_STATUS: begin
               nxt_prdata[STS_OUT_VALID_BIT] = outValid;
               nxt_prdata[STS_IN_READY_BIT] = bufInReady;
            end
            default: begin
               nxt_prdata = WORD_ZERO;   // Unmapped reads as zero
            end
         endcase
      end
   end

   // Count descriptors taken with a copy. The counter wraps silently;
   // software wanting a rate reads it twice and takes the difference
   // modulo the word size.
   always_comb begin
      nxt_copyCount = copyCount_ff;
      if (accept && copyHit) begin
         nxt_copyCount = copyCount_ff + COUNT_ONE;
      end
   end

   // ==========================================================
   // Configuration registers; reset leaves every copy condition off except the rule match, which has no enable
   always_ff @(posedge clk) begin
      if (!nrst) begin
         ingressCopyEnable_ff <= MASK_RESET;
         egressCopyPortMask_ff <= MASK_RESET;
         copyDestinationMask_ff <= MASK_RESET;
         cpuCopy_ff <= 1'b0;
         learnCopy_ff <= 1'b0;
         cpuCopyQueueSelect_ff <= QSEL_RESET;
         vlanTableIndex_ff <= '0;
      end else begin
         ingressCopyEnable_ff <= nxt_ingressCopyEnable;
         egressCopyPortMask_ff <= nxt_egressCopyPortMask;
         copyDestinationMask_ff <= nxt_copyDestinationMask;
         cpuCopy_ff <= nxt_cpuCopy;
         learnCopy_ff <= nxt_learnCopy;
         cpuCopyQueueSelect_ff <= nxt_cpuCopyQueueSelect;
         vlanTableIndex_ff <= nxt_vlanTableIndex;
      end
   end

   // Copy counter
   always_ff @(posedge clk) begin
      if (!nrst) begin
         copyCount_ff <= WORD_ZERO;
      end else begin
         copyCount_ff <= nxt_copyCount;
      end
   end

   // Bus answer; each of these stands for one cycle only
   always_ff @(posedge clk) begin
      if (!nrst) begin
         prdata_ff <= WORD_ZERO;
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
      end else begin
         prdata_ff <= nxt_prdata;
         pready_ff <= nxt_pready;
         pslverr_ff <= nxt_pslverr;
      end
   end

   // Flag table write port: one flag per write, at the held table index
   logic flagWrEn;
   logic [VID_W-1:0] flagWrIdx;
   logic flagWrVal;
   always_comb begin
      flagWrEn = vlanFlagWrite;
      flagWrIdx = vlanTableIndex_ff;
      flagWrVal = pwdata[0];
   end

   // Flag table; reset clears every flag, which costs a wide reset fan-out
   always_ff @(posedge clk) begin
      if (!nrst) begin
         for (int i = 0; i < NUM_VIDS; i++) begin
            perVidCopyFlag[i] <= 1'b0;
         end
      end else if (flagWrEn) begin
         perVidCopyFlag[flagWrIdx] <= flagWrVal;
      end
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
endmodule
`default_nettype wire

// >>> bench/mirror_analyzer_model.sv
/*
 Frame analyzer on the copy port: takes descriptors, promptly or slowly.
 Assumes the bench packs the watched output fields into seen.
*/
`timescale 1ns/1ps
`default_nettype none
module mirror_analyzer_model (
   input wire logic clk,
   input wire logic nrst,
   input wire logic slow,
   input wire logic outValid,
   output logic outReady,
   input wire logic [50:0] seen
);
   // ==========================================================
   // Sink
   logic [50:0] got[$];
   logic [1:0] phase_ff;
   // Slow mode takes one word in four so that the buffer backs up
   assign outReady = !slow || (phase_ff == 2'h3);
   // Record every word taken, in arrival order
   always @(posedge clk) begin
      if (!nrst) begin
         phase_ff <= 2'h0;
      end else begin
         phase_ff <= phase_ff + 2'h1;
         if (outValid && outReady) begin
            got.push_back(seen);
         end
      end
   end
endmodule
`default_nettype wire

// >>> bench/switch_traffic_mirroring_checker.sv
/*
 Port assertions for the mirroring block.
 Assumes it is bound onto switch_traffic_mirroring.
*/
`timescale 1ns/1ps
`default_nettype none
module switch_traffic_mirroring_checker
   import mirror_pkg::*;
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic frameValid,
   input wire logic frameReady,
   input wire logic [PORT_W-1:0] srcPort,
   input wire logic [NUM_PORTS-1:0] fwdMask,
   input wire logic outValid,
   input wire logic outReady,
   input wire logic [PORT_W-1:0] outSrcPort,
   input wire logic [NUM_PORTS-1:0] outFwdMask,
   input wire logic [NUM_PORTS-1:0] outCopyMask,
   input wire logic outCopyToCpu,
   input wire logic outCopyHit
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   // ==========================================================
   // Register bus answers after exactly one wait state
   a_pready_wait_state: assert property (psel && penable && !pready |=> pready)
      else $error("pready late");
   a_pready_one_cycle: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   // ==========================================================
   // Descriptor path: originals pass untouched, stalls hold the word
   a_take_passes_through: assert property (frameValid && frameReady && !outValid |=>
      outValid && outFwdMask == $past(fwdMask) && outSrcPort == $past(srcPort))
      else $error("descriptor not passed through");
   a_stall_holds_word: assert property (outValid && !outReady |=>
      outValid && $stable(outCopyMask) && $stable(outFwdMask))
      else $error("output changed during stall");
   a_no_hit_no_copy: assert property (outValid && !outCopyHit |-> outCopyMask == '0)
      else $error("copy mask without hit");
   a_cpu_bit_tracks: assert property (outValid |-> outCopyToCpu == outCopyMask[CPU_PORT])
      else $error("cpu copy flag differs from mask");
   a_full_has_output: assert property (frameValid && !frameReady |-> outValid)
      else $error("refused while empty");
   a_drain_frees_slot: assert property (outValid && outReady && !frameReady |=> frameReady)
      else $error("slot not freed");
   // Main scenarios reached
   c_stall: cover property (outValid && !outReady);
   c_full: cover property (frameValid && !frameReady);
   c_cpu_copy: cover property (outValid && outCopyToCpu);
endmodule
bind switch_traffic_mirroring switch_traffic_mirroring_checker
   u_switch_traffic_mirroring_checker (.clk, .nrst, .psel, .penable, .pready, .pslverr,
   .frameValid, .frameReady, .srcPort, .fwdMask, .outValid, .outReady, .outSrcPort,
   .outFwdMask, .outCopyMask, .outCopyToCpu, .outCopyHit);
`default_nettype wire

// >>> bench/switch_traffic_mirroring_tb_top.sv
/*
 Self-checking bench for the mirroring block: APB tasks and scenarios.
 Assumes the analyzer model sinks the output stream.
*/
`timescale 1ns/1ps
`default_nettype none
module switch_traffic_mirroring_tb_top
   import mirror_pkg::*;
;
   // ==========================================================
   // Signals and expectation state
   logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = WORD_ZERO;
   logic frameValid = 1'b0, learnFrame = 1'b0, ruleCopy = 1'b0, slow = 1'b0;
   logic [3:0] srcPort = 4'h0;
   logic [11:0] classVid = 12'h000, outVid, flagVid = 12'h000;
   logic [10:0] fwdMask = MASK_RESET, outFwdMask, outCopyMask;
   logic [7:0] cpuQueues = 8'h00, outCpuQueues;
   logic [31:0] prdata;
   logic pready, pslverr, frameReady, outValid, outReady, outCopyToCpu, outCopyHit;
   logic [3:0] outSrcPort;
   logic [2:0] outCopyQueue, qsel = 3'h0;
   logic [10:0] ing = 11'h0, eg = 11'h0, dest = 11'h0;
   logic cpuCopy = 1'b0, learnCopy = 1'b0, flagOn = 1'b0, sawFull = 1'b0;
   logic [50:0] expq[$];
   int num_errors = 0, comparisons = 0;
   int hitCount = 0;
   switch_traffic_mirroring u_switch_traffic_mirroring (
      .clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .frameValid, .frameReady, .srcPort, .classVid, .fwdMask, .cpuQueues,
      .learnFrame, .ruleCopy, .outValid, .outReady, .outSrcPort, .outVid, .outFwdMask,
      .outCpuQueues, .outCopyMask, .outCopyToCpu, .outCopyQueue, .outCopyHit);
   // Queue number only means something when the CPU receives the copy
   mirror_analyzer_model u_mirror_analyzer_model (.clk, .nrst, .slow, .outValid,
      .outReady, .seen({outCpuQueues, outVid, outCopyHit, outCopyToCpu,
      outCopyToCpu ? outCopyQueue : 3'h0, outCopyMask, outFwdMask, outSrcPort}));
   // Clock
   initial forever #2 clk = ~clk;
   // ==========================================================
   // Shared tasks
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd, ed,
         input logic ee);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      check(prdata, ed);
      check({31'h0, pslverr}, {31'h0, ee});
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic cfg(input logic [10:0] i, e, d, input logic [31:0] c);
      apb(1'b1, OFS_INGRESS_EN, {21'h0, i}, WORD_ZERO, 1'b0);
      apb(1'b1, OFS_EGRESS_MASK, {21'h0, e}, WORD_ZERO, 1'b0);
      apb(1'b1, OFS_DEST_MASK, {21'h0, d}, WORD_ZERO, 1'b0);
      apb(1'b1, OFS_CONTROL, c, WORD_ZERO, 1'b0);
      ing = i;
      eg = e;
      dest = d;
      cpuCopy = c[0];
      learnCopy = c[1];
      qsel = c[6:4];
   endtask
   // Expected copy result is worked out from the shadow settings
   task automatic frame(input logic [3:0] s, input logic [11:0] v, input logic [10:0] f,
         input logic [7:0] q, input logic l, r);
      int n;
      logic hit;
      hit = ing[s] | (|(f & eg)) | (flagOn && v == flagVid) | (cpuCopy & (|q))
         | (learnCopy & l) | r;
      expq.push_back({q, v, hit, hit & dest[10], (hit & dest[10]) ? qsel : 3'h0,
         hit ? dest : 11'h0, f, s});
      if (hit) hitCount++;
      frameValid <= 1'b1;
      srcPort <= s;
      classVid <= v;
      fwdMask <= f;
      cpuQueues <= q;
      learnFrame <= l;
      ruleCopy <= r;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (frameReady !== 1'b1);
      if (n > 1) sawFull = 1'b1;
   endtask
   task automatic drain;
      int n;
      logic [50:0] g, e;
      frameValid <= 1'b0;
      slow <= 1'b0;
      @(posedge clk);
      n = 0;
      while (u_mirror_analyzer_model.got.size() < expq.size() && n < 200) begin
         @(posedge clk);
         n++;
      end
      check(32'(u_mirror_analyzer_model.got.size()), 32'(expq.size()));
      while (expq.size() > 0 && u_mirror_analyzer_model.got.size() > 0) begin
         g = u_mirror_analyzer_model.got.pop_front();
         e = expq.pop_front();
         check({1'b0, g[30:0]}, {1'b0, e[30:0]});
         check({12'h000, g[50:31]}, {12'h000, e[50:31]});
      end
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_regs;
      apb(1'b0, OFS_DEST_MASK, WORD_ZERO, WORD_ZERO, 1'b0);
      apb(1'b1, OFS_DEST_MASK, 32'h0000_0404, WORD_ZERO, 1'b0);
      apb(1'b0, OFS_DEST_MASK, WORD_ZERO, 32'h0000_0404, 1'b0);
      apb(1'b0, 8'h20, WORD_ZERO, WORD_ZERO, 1'b1);
      apb(1'b1, OFS_COPY_COUNT, 32'h0000_0005, WORD_ZERO, 1'b1);
      apb(1'b0, OFS_STATUS, WORD_ZERO, 32'h0000_0002, 1'b0);
   endtask
   task automatic t_ports;
      cfg(11'h008, 11'h008, 11'h004, WORD_ZERO);
      frame(4'h3, 12'h001, 11'h001, 8'h00, 1'b0, 1'b0);
      frame(4'h5, 12'h001, 11'h009, 8'h00, 1'b0, 1'b0);
      frame(4'h5, 12'h001, 11'h001, 8'h00, 1'b0, 1'b0);
      drain();
   endtask
   task automatic t_vlan;
      apb(1'b1, OFS_VLAN_INDEX, 32'h0000_0064, WORD_ZERO, 1'b0);
      apb(1'b1, OFS_VLAN_FLAG, COUNT_ONE, WORD_ZERO, 1'b0);
      apb(1'b0, OFS_VLAN_FLAG, WORD_ZERO, COUNT_ONE, 1'b0);
      flagVid = 12'h064;
      flagOn = 1'b1;
      frame(4'h1, 12'h064, 11'h001, 8'h00, 1'b0, 1'b0);
      frame(4'h1, 12'h065, 11'h001, 8'h00, 1'b0, 1'b0);
      drain();
   endtask
   task automatic t_cpu;
      cfg(11'h000, 11'h000, 11'h402, 32'h0000_0053);
      apb(1'b0, OFS_CONTROL, WORD_ZERO, 32'h0000_0053, 1'b0);
      frame(4'h2, 12'h001, 11'h400, 8'h80, 1'b0, 1'b0);
      frame(4'h2, 12'h001, 11'h001, 8'h00, 1'b1, 1'b0);
      frame(4'h2, 12'h001, 11'h001, 8'h00, 1'b0, 1'b0);
      drain();
   endtask
   task automatic t_stall;
      cfg(11'h001, 11'h000, 11'h010, WORD_ZERO);
      slow <= 1'b1;
      for (int k = 0; k < 6; k++)
         frame(4'(k % 2), 12'h002, 11'h002, 8'h00, 1'b0, k[1]);
      drain();
      check({31'h0, sawFull}, COUNT_ONE);
      apb(1'b0, OFS_COPY_COUNT, WORD_ZERO, 32'(hitCount), 1'b0);
   endtask
   task automatic tally_and_finish;
      if (num_errors == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // Main sequence, then a watchdog against hangs
   initial begin
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      t_regs();
      t_ports();
      t_vlan();
      t_cpu();
      t_stall();
      tally_and_finish();
   end
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
